// ===== i2c_ctl_pkg.sv
// Constants, states and carriers for the two-wire control slave port.
// Assumes the link logic runs on the master's SCL and the user side on mclk_i.
package i2c_ctl_pkg;

  localparam int          BYTE_W         = 8;
  localparam int          SUB_W          = 12;
  localparam int          LEN_W          = 3;
  localparam int          WORD_W         = 40;
  localparam int          CNT_W          = 4;
  localparam int          MAX_WORD_BYTES = 5;

  // Fixed upper part of the seven-bit slave address
  localparam logic [4:0]  DEV_ADDR_FIXED = 5'h0D;

  // Bit counter positions within one nine-clock byte slot
  localparam logic [CNT_W-1:0] CNT_FIRST = 4'h1;
  localparam logic [CNT_W-1:0] CNT_LAST  = 4'h7;
  localparam logic [CNT_W-1:0] CNT_ACK   = 4'h8;

  localparam logic [3:0]  SUB_HI_PAD     = 4'h0;
  localparam logic        DIR_READ       = 1'b1;

  // Default decode table: four ranges, arbitrary plain values
  localparam int          DEF_REGIONS    = 4;
  localparam logic [DEF_REGIONS*SUB_W-1:0] DEF_BASE =
    {12'h810, 12'h800, 12'h400, 12'h000};
  localparam logic [DEF_REGIONS*SUB_W-1:0] DEF_TOP  =
    {12'h81F, 12'h80F, 12'h5FF, 12'h3FF};
  localparam logic [DEF_REGIONS*LEN_W-1:0] DEF_LEN  =
    {3'h2, 3'h4, 3'h5, 3'h4};
  localparam logic [SUB_W-1:0] DEF_TOP_SUB = 12'h81F;

  // Position of the byte within a transfer
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DEV    = 3'b001,
    ST_SUB_HI = 3'b010,
    ST_SUB_LO = 3'b011,
    ST_WR     = 3'b100,
    ST_RD     = 3'b101
  } link_state_e;

  // One whole word written by the master, right aligned
  typedef struct packed {
    logic [SUB_W-1:0]  addr;
    logic [LEN_W-1:0]  len;
    logic [WORD_W-1:0] data;
  } wr_cmd_s;

endpackage

// ===== word_len_decode.sv
// Subaddress decode table: validity and word length per range.
// Assumes ranges do not overlap; the lowest numbered hit wins anyway.
`timescale 1ns/1ns
`default_nettype none
module word_len_decode #(
  parameter int                                            NUM_REGIONS = i2c_ctl_pkg::DEF_REGIONS,
  parameter logic [NUM_REGIONS*i2c_ctl_pkg::SUB_W-1:0]     REGION_BASE = i2c_ctl_pkg::DEF_BASE,
  parameter logic [NUM_REGIONS*i2c_ctl_pkg::SUB_W-1:0]     REGION_TOP  = i2c_ctl_pkg::DEF_TOP,
  parameter logic [NUM_REGIONS*i2c_ctl_pkg::LEN_W-1:0]     REGION_LEN  = i2c_ctl_pkg::DEF_LEN
) (
  input  wire logic [i2c_ctl_pkg::SUB_W-1:0] addr_i,  // Subaddress to decode
  output logic                               valid_o, // Address lies in a range
  output logic [i2c_ctl_pkg::LEN_W-1:0]      len_o    // Word length in bytes
);

  logic [NUM_REGIONS-1:0]                      hit;
  logic [NUM_REGIONS*i2c_ctl_pkg::LEN_W-1:0]   hit_len;

  // Range compare per table entry
  genvar g;
  generate
    for (g = 0; g < NUM_REGIONS; g++) begin : g_region
      assign hit[g] = (addr_i >= REGION_BASE[g*i2c_ctl_pkg::SUB_W +: i2c_ctl_pkg::SUB_W]) &&
                      (addr_i <= REGION_TOP[g*i2c_ctl_pkg::SUB_W +: i2c_ctl_pkg::SUB_W]);
      assign hit_len[g*i2c_ctl_pkg::LEN_W +: i2c_ctl_pkg::LEN_W] =
        REGION_LEN[g*i2c_ctl_pkg::LEN_W +: i2c_ctl_pkg::LEN_W];
    end
  endgenerate

  // Pick the first hit; unmatched addresses are invalid
  always_comb begin
    valid_o = 1'b0;
    len_o   = '0;
    for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        valid_o = 1'b1;
        len_o   = hit_len[i*i2c_ctl_pkg::LEN_W +: i2c_ctl_pkg::LEN_W];
      end
    end
  end

  // Refuse table entries the word buffer cannot hold
  generate
    for (g = 0; g < NUM_REGIONS; g++) begin : g_check
      if (REGION_LEN[g*i2c_ctl_pkg::LEN_W +: i2c_ctl_pkg::LEN_W] == 0 ||
          REGION_LEN[g*i2c_ctl_pkg::LEN_W +: i2c_ctl_pkg::LEN_W] > i2c_ctl_pkg::MAX_WORD_BYTES)
      begin : g_bad
        $error("word length out of range");
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== i2c_control_slave_port.sv
// Two-wire control slave port: address match, subaddress, burst words.
// Assumes an external master drives SCL; the wire level of SDA is resolved
// outside from sda_oe_o. The user side answers reads on mclk_i.
`timescale 1ns/1ns
`default_nettype none
module i2c_control_slave_port #(
  parameter int                                        NUM_REGIONS = i2c_ctl_pkg::DEF_REGIONS,
  parameter logic [NUM_REGIONS*i2c_ctl_pkg::SUB_W-1:0] REGION_BASE = i2c_ctl_pkg::DEF_BASE,
  parameter logic [NUM_REGIONS*i2c_ctl_pkg::SUB_W-1:0] REGION_TOP  = i2c_ctl_pkg::DEF_TOP,
  parameter logic [NUM_REGIONS*i2c_ctl_pkg::LEN_W-1:0] REGION_LEN  = i2c_ctl_pkg::DEF_LEN,
  parameter logic [i2c_ctl_pkg::SUB_W-1:0]             TOP_SUBADDR = i2c_ctl_pkg::DEF_TOP_SUB
) (
  input  wire logic                              mclk_i,                 // System clock
  input  wire logic                              rstn_i,                 // Async reset, low
  input  wire logic                              scl_i,                  // Link clock from master
  input  wire logic                              sda_i,                  // SDA wire level
  output logic                                   sda_o,                  // SDA drive value
  output logic                                   sda_oe_o,               // SDA pull low enable
  input  wire logic                              addr_select_low_pin_i,  // Address bit 0 strap
  input  wire logic                              addr_select_high_pin_i, // Address bit 1 strap
  output logic                                   wr_valid_o,             // Word write pulse
  output i2c_ctl_pkg::wr_cmd_s                   wr_cmd_o,               // Word write payload
  output logic                                   rd_req_o,               // Word read pulse
  output logic [i2c_ctl_pkg::SUB_W-1:0]          rd_addr_o,              // Word read address
  input  wire logic                              rd_valid_i,             // Read data strobe
  input  wire logic [i2c_ctl_pkg::WORD_W-1:0]    rd_data_i,              // Read word, right aligned
  output logic                                   frame_active_o          // Transfer in progress
);

  // Table must hold at least one decode range
  generate
    if (NUM_REGIONS < 1) begin : g_bad_regions
      $error("at least one decode range needed");
    end
  endgenerate

  // ---------------- Link side, clocked by SCL ----------------
  logic                                  start_tog_r;
  logic                                  stop_tog_r;
  logic                                  start_seen_r;
  logic                                  stop_seen_r;
  logic [1:0]                            pin_meta_r;
  logic [1:0]                            pin_sync_r;
  i2c_ctl_pkg::link_state_e              state_r;
  i2c_ctl_pkg::link_state_e              next_state_r;
  i2c_ctl_pkg::link_state_e              state_nxt;
  logic [i2c_ctl_pkg::CNT_W-1:0]         cnt_r;
  logic [i2c_ctl_pkg::BYTE_W-1:0]        shift_r;
  logic                                  ack_r;
  logic                                  ack_nxt;
  logic                                  rw_r;
  logic [3:0]                            sub_hi_r;
  logic [i2c_ctl_pkg::SUB_W-1:0]         sub_r;
  logic [i2c_ctl_pkg::LEN_W-1:0]         len_r;
  logic [i2c_ctl_pkg::LEN_W-1:0]         byte_idx_r;
  logic                                  sub_ok_r;
  logic                                  over_r;
  logic [i2c_ctl_pkg::WORD_W-9:0]        acc_r;
  i2c_ctl_pkg::wr_cmd_s                  wr_hold_r;
  logic                                  wr_tog_r;
  logic [i2c_ctl_pkg::SUB_W-1:0]         rd_addr_hold_r;
  logic                                  rd_tog_r;
  logic [i2c_ctl_pkg::WORD_W-1:0]        tx_word_r;
  logic [i2c_ctl_pkg::BYTE_W-1:0]        tx_byte_r;
  logic                                  busy_r;
  logic                                  sda_oe_r;
  logic                                  sda_drv_r;

  logic                                  start_seen;
  logic                                  stop_seen;
  logic                                  active;
  logic                                  byte_done;
  logic                                  ack_slot;
  logic [i2c_ctl_pkg::BYTE_W-1:0]        rx_byte;
  logic [6:0]                            own_addr;
  logic                                  dec_valid;
  logic [i2c_ctl_pkg::LEN_W-1:0]         dec_len;
  logic                                  word_end;
  logic                                  tx_load;
  logic                                  wr_byte;
  logic                                  sub_set;
  logic [i2c_ctl_pkg::SUB_W-1:0]         sub_step;
  logic [i2c_ctl_pkg::WORD_W-1:0]        tx_src;
  logic [i2c_ctl_pkg::LEN_W-1:0]         tx_sel;
  logic [i2c_ctl_pkg::WORD_W-1:0]        rd_word_r;

  // Start: SDA falls while SCL is high, caught on the SDA edge itself
  always_ff @(negedge sda_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_tog_r <= 1'b0;
    end else if (scl_i) begin
      start_tog_r <= ~start_tog_r;
    end
  end

  // Stop: SDA rises while SCL is high
  always_ff @(posedge sda_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_tog_r <= 1'b0;
    end else if (scl_i) begin
      stop_tog_r <= ~stop_tog_r;
    end
  end

  // Toggles settle during SCL high/low before the next rising edge
  assign start_seen = start_tog_r ^ start_seen_r;
  assign stop_seen  = stop_tog_r ^ stop_seen_r;
  assign active     = (state_r != i2c_ctl_pkg::ST_IDLE) && !start_seen && !stop_seen;
  assign byte_done  = active && (cnt_r == i2c_ctl_pkg::CNT_LAST);
  assign ack_slot   = active && (cnt_r == i2c_ctl_pkg::CNT_ACK);
  assign rx_byte    = {shift_r[6:0], sda_i};
  assign own_addr   = {i2c_ctl_pkg::DEV_ADDR_FIXED, pin_sync_r[1], pin_sync_r[0]};
  assign word_end   = byte_idx_r == (len_r - 3'h1);
  assign sub_step   = (sub_r == TOP_SUBADDR) ? sub_r : sub_r + 12'h001;
  assign wr_byte    = byte_done && (state_r == i2c_ctl_pkg::ST_WR) && !over_r;
  assign sub_set    = byte_done && (state_r == i2c_ctl_pkg::ST_SUB_LO) && dec_valid;
  assign tx_load    = ack_slot && (((state_r == i2c_ctl_pkg::ST_DEV) && ack_r && rw_r) ||
                                   ((state_r == i2c_ctl_pkg::ST_RD) && !sda_i));
  assign tx_src     = (byte_idx_r == '0) ? rd_word_r : tx_word_r;
  assign tx_sel     = len_r - 3'h1 - byte_idx_r;

  // Decode the subaddress as it completes
  word_len_decode #(
    .NUM_REGIONS (NUM_REGIONS),
    .REGION_BASE (REGION_BASE),
    .REGION_TOP  (REGION_TOP),
    .REGION_LEN  (REGION_LEN)
  ) u_decode (
    .addr_i  ({sub_hi_r, rx_byte}),
    .valid_o (dec_valid),
    .len_o   (dec_len)
  );

  // Straps pass two flops before use
  always_ff @(posedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_r <= 2'h0;
      pin_sync_r <= 2'h0;
    end else begin
      pin_meta_r <= {addr_select_high_pin_i, addr_select_low_pin_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  // Acknowledge decision and following byte kind at the eighth bit
  always_comb begin
    ack_nxt   = 1'b0;
    state_nxt = i2c_ctl_pkg::ST_IDLE;
    case (state_r)
      i2c_ctl_pkg::ST_DEV: begin
        // Read needs a subaddress set by an earlier write
        ack_nxt   = (rx_byte[7:1] == own_addr) &&
                    ((rx_byte[0] != i2c_ctl_pkg::DIR_READ) || sub_ok_r);
        state_nxt = (rx_byte[0] == i2c_ctl_pkg::DIR_READ) ?
                    i2c_ctl_pkg::ST_RD : i2c_ctl_pkg::ST_SUB_HI;
      end
      i2c_ctl_pkg::ST_SUB_HI: begin
        ack_nxt   = rx_byte[7:4] == i2c_ctl_pkg::SUB_HI_PAD;
        state_nxt = i2c_ctl_pkg::ST_SUB_LO;
      end
      i2c_ctl_pkg::ST_SUB_LO: begin
        ack_nxt   = dec_valid;
        state_nxt = i2c_ctl_pkg::ST_WR;
      end
      i2c_ctl_pkg::ST_WR: begin
        ack_nxt   = !over_r;
        state_nxt = i2c_ctl_pkg::ST_WR;
      end
      i2c_ctl_pkg::ST_RD: begin
        ack_nxt   = 1'b0;
        state_nxt = i2c_ctl_pkg::ST_RD;
      end
      default: begin
        ack_nxt   = 1'b0;
        state_nxt = i2c_ctl_pkg::ST_IDLE;
      end
    endcase
  end

  // Byte framing: state, bit counter, shifter, acknowledge
  always_ff @(posedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_seen_r <= 1'b0;
      stop_seen_r  <= 1'b0;
      state_r      <= i2c_ctl_pkg::ST_IDLE;
      next_state_r <= i2c_ctl_pkg::ST_IDLE;
      cnt_r        <= '0;
      shift_r      <= '0;
      ack_r        <= 1'b0;
      rw_r         <= 1'b0;
    end else begin
      start_seen_r <= start_tog_r;
      stop_seen_r  <= stop_tog_r;
      if (start_seen) begin
        // This edge clocks the first address bit
        state_r <= i2c_ctl_pkg::ST_DEV;
        cnt_r   <= i2c_ctl_pkg::CNT_FIRST;
        shift_r <= {7'h00, sda_i};
        ack_r   <= 1'b0;
      end else if (stop_seen) begin
        state_r <= i2c_ctl_pkg::ST_IDLE;
        cnt_r   <= '0;
        ack_r   <= 1'b0;
      end else if (ack_slot) begin
        cnt_r <= '0;
        if (state_r == i2c_ctl_pkg::ST_RD) begin
          state_r <= sda_i ? i2c_ctl_pkg::ST_IDLE : i2c_ctl_pkg::ST_RD;
        end else begin
          state_r <= ack_r ? next_state_r : i2c_ctl_pkg::ST_IDLE;
        end
        ack_r <= 1'b0;
      end else if (active) begin
        cnt_r   <= cnt_r + 4'h1;
        shift_r <= rx_byte;
        if (byte_done) begin
          ack_r        <= ack_nxt;
          next_state_r <= state_nxt;
          if (state_r == i2c_ctl_pkg::ST_DEV) begin
            rw_r <= rx_byte[0];
          end
        end
      end
    end
  end

  // Subaddress pointer, word position and top-of-map tracking
  always_ff @(posedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sub_hi_r   <= '0;
      sub_r      <= '0;
      len_r      <= 3'h1;
      byte_idx_r <= '0;
      sub_ok_r   <= 1'b0;
      over_r     <= 1'b0;
    end else if (start_seen) begin
      byte_idx_r <= '0;
    end else if (byte_done && (state_r == i2c_ctl_pkg::ST_SUB_HI)) begin
      sub_hi_r <= rx_byte[3:0];
    end else if (byte_done && (state_r == i2c_ctl_pkg::ST_SUB_LO)) begin
      sub_ok_r   <= dec_valid;
      sub_r      <= {sub_hi_r, rx_byte};
      len_r      <= dec_len;
      byte_idx_r <= '0;
      over_r     <= 1'b0;
    end else if (wr_byte || tx_load) begin
      if (word_end) begin
        byte_idx_r <= '0;
        sub_r      <= sub_step;
        if (wr_byte && (sub_r == TOP_SUBADDR)) begin
          over_r <= 1'b1;
        end
      end else begin
        byte_idx_r <= byte_idx_r + 3'h1;
      end
    end
  end

  // Assemble written words and hand each finished one to mclk
  always_ff @(posedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_r     <= '0;
      wr_hold_r <= '0;
      wr_tog_r  <= 1'b0;
    end else if (start_seen) begin
      acc_r <= '0; // Partial word dropped on any start
    end else if (wr_byte) begin
      if (word_end) begin
        wr_hold_r.addr <= sub_r;
        wr_hold_r.len  <= len_r;
        wr_hold_r.data <= {acc_r, rx_byte};
        wr_tog_r       <= ~wr_tog_r;
        acc_r          <= '0;
      end else begin
        acc_r <= {acc_r[i2c_ctl_pkg::WORD_W-17:0], rx_byte};
      end
    end
  end

  // Read side: prefetch request and byte loading, MSB byte first
  always_ff @(posedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_addr_hold_r <= '0;
      rd_tog_r       <= 1'b0;
      tx_word_r      <= '0;
      tx_byte_r      <= '0;
    end else if (sub_set) begin
      rd_addr_hold_r <= {sub_hi_r, rx_byte};
      rd_tog_r       <= ~rd_tog_r;
    end else if (tx_load) begin
      tx_word_r <= tx_src;
      tx_byte_r <= tx_src[{tx_sel, 3'h0} +: i2c_ctl_pkg::BYTE_W];
      // Next word is fetched early; at the top the same word repeats
      if (word_end) begin
        rd_addr_hold_r <= sub_step;
        rd_tog_r       <= ~rd_tog_r;
      end
    end
  end

  // SDA changes on SCL falling edges only; pull low for ACK or a zero bit
  always_ff @(negedge scl_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_oe_r  <= 1'b0;
      sda_drv_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      sda_drv_r <= 1'b0;
      busy_r    <= state_r != i2c_ctl_pkg::ST_IDLE;
      if (state_r == i2c_ctl_pkg::ST_IDLE) begin
        sda_oe_r <= 1'b0;
      end else if (cnt_r == i2c_ctl_pkg::CNT_ACK) begin
        sda_oe_r <= ack_r;
      end else if (state_r == i2c_ctl_pkg::ST_RD) begin
        sda_oe_r <= !tx_byte_r[3'h7 - cnt_r[2:0]];
      end else begin
        sda_oe_r <= 1'b0;
      end
    end
  end

  assign sda_o    = sda_drv_r;
  assign sda_oe_o = sda_oe_r;

  // ---------------- User side, clocked by mclk ----------------
  logic [2:0] wr_sync_r;
  logic [2:0] rd_sync_r;
  logic [1:0] busy_sync_r;

  // Toggle and level crossings into mclk
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_sync_r   <= '0;
      rd_sync_r   <= '0;
      busy_sync_r <= '0;
    end else begin
      wr_sync_r   <= {wr_sync_r[1:0], wr_tog_r};
      rd_sync_r   <= {rd_sync_r[1:0], rd_tog_r};
      busy_sync_r <= {busy_sync_r[0], busy_r};
    end
  end

  // Word write strobe; payload held stable by the link until next word
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_valid_o <= 1'b0;
      wr_cmd_o   <= '0;
    end else begin
      wr_valid_o <= wr_sync_r[2] ^ wr_sync_r[1];
      if (wr_sync_r[2] ^ wr_sync_r[1]) begin
        wr_cmd_o <= wr_hold_r;
      end
    end
  end

  // Word read request and captured answer
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_req_o  <= 1'b0;
      rd_addr_o <= '0;
      rd_word_r <= '0;
    end else begin
      rd_req_o <= rd_sync_r[2] ^ rd_sync_r[1];
      if (rd_sync_r[2] ^ rd_sync_r[1]) begin
        rd_addr_o <= rd_addr_hold_r;
      end
      if (rd_valid_i) begin
        rd_word_r <= rd_data_i;
      end
    end
  end

  // Transfer status for the user side
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_active_o <= 1'b0;
    end else begin
      frame_active_o <= busy_sync_r[1];
    end
  end

endmodule
`default_nettype wire

// ===== i2c_ctl_asserts.sv
// Concurrent checks on the control slave port pins.
// Assumes the default decode table and a bind onto the port's top module.
`timescale 1ns/1ns
`default_nettype none
module i2c_ctl_asserts #(
  parameter logic [i2c_ctl_pkg::SUB_W-1:0] TOP_SUBADDR = i2c_ctl_pkg::DEF_TOP_SUB
) (
  input wire logic                           mclk_i,                 // Clock
  input wire logic                           rstn_i,                 // Reset
  input wire logic                           scl_i,                  // Link clock
  input wire logic                           sda_i,                  // Wire
  input wire logic                           sda_o,                  // Drive
  input wire logic                           sda_oe_o,               // Pull
  input wire logic                           addr_select_low_pin_i,  // Strap
  input wire logic                           addr_select_high_pin_i, // Strap
  input wire logic                           wr_valid_o,             // Write
  input wire i2c_ctl_pkg::wr_cmd_s           wr_cmd_o,               // Word
  input wire logic                           rd_req_o,               // Fetch
  input wire logic [i2c_ctl_pkg::SUB_W-1:0]  rd_addr_o,              // Address
  input wire logic                           rd_valid_i,             // Strobe
  input wire logic [i2c_ctl_pkg::WORD_W-1:0] rd_data_i,              // Data
  input wire logic                           frame_active_o          // Busy
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Pin and user side relations
  a_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("sda drive value not low");
  a_wr_one_pulse: assert property (wr_valid_o |=> !wr_valid_o)
    else $error("write pulse too long");
  a_rd_one_pulse: assert property (rd_req_o |=> !rd_req_o)
    else $error("fetch pulse too long");
  a_word_holds: assert property ($changed(wr_cmd_o) |-> wr_valid_o)
    else $error("word changed without pulse");
  a_raddr_holds: assert property ($changed(rd_addr_o) |-> rd_req_o)
    else $error("read address changed without pulse");
  a_len_range: assert property (wr_valid_o |-> wr_cmd_o.len inside {[3'h1:3'h5]})
    else $error("word length out of range");
  a_data_fits_len: assert property (wr_valid_o |-> (wr_cmd_o.data >> (8 * wr_cmd_o.len)) == 0)
    else $error("word wider than length");
  a_wr_not_top: assert property (wr_valid_o |-> wr_cmd_o.addr <= TOP_SUBADDR)
    else $error("write above top");
  a_rd_not_top: assert property (rd_req_o |-> rd_addr_o <= TOP_SUBADDR)
    else $error("fetch above top");
  c_word: cover property (wr_valid_o);
  c_fetch: cover property (rd_req_o);
  c_ack: cover property ($rose(sda_oe_o));
endmodule
bind i2c_control_slave_port i2c_ctl_asserts #(.TOP_SUBADDR(TOP_SUBADDR)) u_asserts (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .addr_select_low_pin_i(addr_select_low_pin_i),
  .addr_select_high_pin_i(addr_select_high_pin_i), .wr_valid_o(wr_valid_o),
  .wr_cmd_o(wr_cmd_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
  .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i), .frame_active_o(frame_active_o));
`default_nettype wire

// ===== i2c_master_model.sv
// Two-wire bus master model: drives SCL, pulls SDA low when asked.
// Assumes a pull-up resolves SDA outside; SCL stands high between frames.
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
  output logic      scl_o,  // Link clock, 32 ns
  output logic      pull_o, // Master pulls SDA low
  input  wire logic sda_i   // Resolved wire
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // One bit slot: data set while SCL low, sampled in the high phase
  task automatic bit_io(input logic b, output logic r);
    pull_o = !b;
    #8 scl_o = 1'b1;
    #8 r = sda_i;
    #8 scl_o = 1'b0;
    #8;
  endtask
  // Start or repeated start
  task automatic start();
    pull_o = 1'b0;
    #8 scl_o = 1'b1;
    #8 pull_o = 1'b1;
    #8 scl_o = 1'b0;
    #8;
  endtask
  // Stop, then the clock stands high
  task automatic stop();
    pull_o = 1'b1;
    #8 scl_o = 1'b1;
    #8 pull_o = 1'b0;
    #16;
  endtask
  // Byte out, MSB first; returns the slave acknowledge
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in; acknowledge, or leave SDA high on the last
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// ===== i2c_control_slave_port_tb.sv
// Self-checking bench for the control slave port with a master model.
// Assumes the default decode table; reads return the word's own address.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module i2c_control_slave_port_tb;
  logic mclk = 1'b0, rstn = 1'b1, sel_lo = 1'b0, sel_hi = 1'b0, rd_valid = 1'b0;
  logic scl, pull, sda, sda_o, sda_oe, wr_valid, rd_req, frame, ack;
  logic [11:0] rd_addr;
  logic [39:0] rd_data = '0;
  logic [7:0] d;
  i2c_ctl_pkg::wr_cmd_s wr_cmd;
  i2c_ctl_pkg::wr_cmd_s wq[$];
  int n_mismatch = 0, n_compared = 0;
  assign sda = !(pull | sda_oe);
  i2c_master_model m (.scl_o(scl), .pull_o(pull), .sda_i(sda));
  i2c_control_slave_port uut (.mclk_i(mclk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_low_pin_i(sel_lo),
    .addr_select_high_pin_i(sel_hi), .wr_valid_o(wr_valid), .wr_cmd_o(wr_cmd),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .frame_active_o(frame));
  initial forever #50 mclk = ~mclk;
  // User side: words are answered at once, collected writes queued
  always @(posedge mclk) begin
    if (wr_valid === 1'b1) wq.push_back(wr_cmd);
    #1 rd_valid = rd_req;
    rd_data = {28'h0, rd_addr};
  end
  task automatic send(input logic [7:0] b, input logic exp);
    m.wr(b, ack);
    `CHK(ack, exp)
  endtask
  task automatic settle(input int n);
    m.stop();
    repeat (6) @(posedge mclk);
    `CHK(wq.size(), n)
  endtask
  task automatic t_burst();
    m.start(); send(8'h68, 1); send(8'h04, 1); send(8'h00, 1);
    for (int i = 1; i <= 10; i++) send(i[7:0], 1);
    `CHK(frame, 1'b1)
    settle(2);
    `CHK(wq[0], {12'h400, 3'h5, 40'h0102030405})
    `CHK(wq[1], {12'h401, 3'h5, 40'h060708090A})
    wq.delete();
  endtask
  task automatic t_bad_sub();
    m.start(); send(8'h68, 1); send(8'h07, 1); send(8'h00, 0); m.stop();
    m.start(); send(8'h68, 1); send(8'h14, 0); send(8'h00, 0); m.stop();
  endtask
  task automatic t_top();
    m.start(); send(8'h68, 1); send(8'h08, 1); send(8'h1F, 1);
    send(8'hAA, 1); send(8'hBB, 1); send(8'hCC, 0);
    settle(1);
    `CHK(wq[0], {12'h81F, 3'h2, 40'hAABB})
    wq.delete();
  endtask
  task automatic t_read();
    m.start(); send(8'h68, 1); send(8'h08, 1); send(8'h1E, 1);
    #600;
    m.start(); send(8'h69, 1);
    for (int i = 0; i < 6; i++) begin
      m.rd(i == 5, d);
      `CHK(d, i[0] ? (i == 1 ? 8'h1E : 8'h1F) : 8'h08)
      #400; // SCL held low so the prefetched word lands before it is needed
    end
    m.stop();
  endtask
  task automatic t_abort();
    m.start(); send(8'h68, 1); send(8'h00, 1); send(8'h10, 1); send(8'h11, 1);
    m.start(); send(8'h68, 1); send(8'h00, 1); send(8'h10, 1);
    for (int i = 3; i <= 6; i++) send({i[3:0], i[3:0]}, 1);
    settle(1);
    `CHK(wq[0], {12'h010, 3'h4, 40'h0033445566})
    wq.delete();
  endtask
  task automatic t_address();
    for (int p = 1; p <= 4; p++) begin
      @(posedge mclk);
      #1 {sel_lo, sel_hi} = p[1:0];
      m.start(); send(8'h60, 0); m.stop();
      m.start(); send(8'h68 | {5'h0, p[0], p[1], 1'b0}, 1); m.stop();
    end
  endtask
  task automatic final_report();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1 rstn = 1'b0; // A real falling edge so the SCL side resets too
    repeat (12) @(posedge mclk);
    #1 rstn = 1'b1;
    t_address();
    t_burst();
    t_bad_sub();
    t_top();
    t_read();
    t_abort();
    final_report();
  end
  initial begin
    #300000 n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
